// file: logic/orbc_params.svh
// constants for output routing and brake control: offsets, fields, timing
// assumes 32-bit APB, 100 MHz clk
// Function
// - routing mode only when routing enable set
// - routing ignores normal output config entries
// - route entry: high byte source, low byte bit
// - entries map brake, outputs 1 to 4
// - bit 7 inverts the control bit
// - source 00 high, 01 low
// - 02..08 encoder pulses divided 1..64
// - 09..0f position pulses divided 1..64
// - 10 brake pwm, 11 inverted pwm
// - fast outputs 10 kHz, others 500 Hz
// - auto brake releases only in operation enabled
// - config bit 2 auto, else control bit 0
// - enable: current, wait3, release, wait4, motion
// - disable: stop, wait1, engage, wait2, current off
// - released brake pwm, frequency hz max 2000
// - duty percent 1..100, 100 continuously on
// - control bit 0 brake, outputs bits 16 up
`ifndef ORBC_PARAMS_SVH
`define ORBC_PARAMS_SVH
`define ORBC_ADDR_ROUTE0 12'h000
`define ORBC_ADDR_CTRLWORD 12'h014
`define ORBC_ADDR_OUTCFG 12'h018
`define ORBC_ADDR_DRVCFG 12'h01c
`define ORBC_ADDR_DELAY1 12'h020
`define ORBC_ADDR_PWMFREQ 12'h030
`define ORBC_ADDR_PWMDUTY 12'h034
`define ORBC_ADDR_STATUS 12'h038
`define ORBC_ROUTE_RESET 16'h0100
`define ORBC_FREQ_RESET 16'h07d0
`define ORBC_DUTY_RESET 8'h64
`define ORBC_FREQ_MAX 16'h07d0
`define ORBC_DUTY_MAX 8'h64
`define ORBC_INV_BIT 7
`define ORBC_ROUTE_EN_BIT 8
`define ORBC_AUTO_BIT 2
`define ORBC_BRAKE_BIT 0
`define ORBC_OUT1_BIT 16
`define ORBC_CLK_HZ 100000000
`define ORBC_MS_CYCLES (`ORBC_CLK_HZ / 1000)
`define ORBC_FAST_HZ 10000
`define ORBC_SLOW_HZ 500
`endif

// file: logic/orbc_pkg.sv
// types for output routing and brake control
// assumes orbc_params.svh for the numbers
package orbc_pkg;
   typedef enum logic [2:0] {
      ORBC_DISABLED = 3'b000,
      ORBC_WAIT_ON = 3'b001,
      ORBC_WAIT_RUN = 3'b011,
      ORBC_ENABLED = 3'b010,
      ORBC_WAIT_ENGAGE = 3'b110,
      ORBC_WAIT_OFF = 3'b111
   } orbc_state_e;
endpackage

// file: logic/orbc_top.sv
// output routing mux and automatic holding-brake sequencer with apb slave
// assumes drive handshake on clk; enable and encoder/position pulses async, synchronized here
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "orbc_params.svh"
module orbc_top
   import orbc_pkg::*;
#(
   parameter int MS_CYCLES = `ORBC_MS_CYCLES,
   parameter int CLK_HZ = `ORBC_CLK_HZ
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic encPulse,
   input wire logic posPulse,
   input wire logic opEnableReq,
   input wire logic motorStopped,
   output logic motorCurrentOn,
   output logic motionAllowed,
   output logic stopRequest,
   output logic brakeOut,
   output logic brakeOutOen,
   output logic [3:0] digOut
);
   logic [15:0] route [0:4];
   logic [31:0] ctrlWord;
   logic [31:0] outCfg;
   logic [31:0] drvCfg;
   logic [15:0] delay [0:3];
   logic [15:0] pwmFreq;
   logic [7:0] pwmDuty;
   logic enSync1, enSync2, encSync1, encSync2, encPrev;
   logic posSync1, posSync2, posPrev;
   logic [5:0] encDiv, posDiv;
   logic encEdge, posEdge;
   orbc_state_e state, next_state;
   logic [15:0] msLeft;
   logic [31:0] msTick;
   logic brakeReleased;
   logic [31:0] pwmCnt, pwmPeriod, pwmOn;
   logic pwmSig;
   logic [4:0] routed;
   logic [4:0] outNow;
   logic [31:0] slowCnt;
   logic slowTick;
   logic wr, rd;
   logic brakeNorm;

   // division of a raw pulse train: one bit of a toggle counter per step
   function automatic logic divSel(input logic [7:0] code,
                                   input logic [7:0] base,
                                   input logic raw,
                                   input logic [5:0] div);
      logic [7:0] k;
      k = code - base;
      if (k == 8'h00)
         divSel = raw;
      else
         divSel = div[k[2:0] - 3'h1];
   endfunction

   assign wr = psel && penable && pwrite;
   assign rd = psel && !pwrite;
   assign pready = 1'b1;
   always_comb begin
      pslverr = 1'b0;
      if (psel && penable && paddr > `ORBC_ADDR_STATUS)
         pslverr = 1'b1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 5; i++)
            route[i] <= `ORBC_ROUTE_RESET;
         ctrlWord <= 32'h0;
         outCfg <= 32'h0;
         drvCfg <= 32'h0;
         for (int i = 0; i < 4; i++)
            delay[i] <= 16'h0;
         pwmFreq <= `ORBC_FREQ_RESET;
         pwmDuty <= `ORBC_DUTY_RESET;
      end else if (wr) begin
         for (int i = 0; i < 5; i++)
            if (paddr == `ORBC_ADDR_ROUTE0 + 12'(4 * i))
               route[i] <= pwdata[15:0];
         for (int i = 0; i < 4; i++)
            if (paddr == `ORBC_ADDR_DELAY1 + 12'(4 * i))
               delay[i] <= pwdata[15:0];
         if (paddr == `ORBC_ADDR_CTRLWORD)
            ctrlWord <= pwdata;
         if (paddr == `ORBC_ADDR_OUTCFG)
            outCfg <= pwdata;
         if (paddr == `ORBC_ADDR_DRVCFG)
            drvCfg <= pwdata;
         // out-of-range frequency or duty is refused, old value kept
         if (paddr == `ORBC_ADDR_PWMFREQ && pwdata[15:0] != 16'h0 &&
             pwdata[15:0] <= `ORBC_FREQ_MAX && pwdata[31:16] == 16'h0)
            pwmFreq <= pwdata[15:0];
         if (paddr == `ORBC_ADDR_PWMDUTY && pwdata[7:0] != 8'h0 &&
             pwdata[7:0] <= `ORBC_DUTY_MAX && pwdata[31:8] == 24'h0)
            pwmDuty <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0;
      end else if (rd && !penable) begin
         prdata <= 32'h0;
         for (int i = 0; i < 5; i++)
            if (paddr == `ORBC_ADDR_ROUTE0 + 12'(4 * i))
               prdata <= {16'h0, route[i]};
         for (int i = 0; i < 4; i++)
            if (paddr == `ORBC_ADDR_DELAY1 + 12'(4 * i))
               prdata <= {16'h0, delay[i]};
         if (paddr == `ORBC_ADDR_CTRLWORD)
            prdata <= ctrlWord;
         if (paddr == `ORBC_ADDR_OUTCFG)
            prdata <= outCfg;
         if (paddr == `ORBC_ADDR_DRVCFG)
            prdata <= drvCfg;
         if (paddr == `ORBC_ADDR_PWMFREQ)
            prdata <= {16'h0, pwmFreq};
         if (paddr == `ORBC_ADDR_PWMDUTY)
            prdata <= {24'h0, pwmDuty};
         if (paddr == `ORBC_ADDR_STATUS)
            prdata <= {22'h0, outNow, state, brakeReleased, pwmSig};
      end
   end

   // pin-side inputs pass two flops before use
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         enSync1 <= 1'b0;
         enSync2 <= 1'b0;
         encSync1 <= 1'b0;
         encSync2 <= 1'b0;
         encPrev <= 1'b0;
         posSync1 <= 1'b0;
         posSync2 <= 1'b0;
         posPrev <= 1'b0;
      end else begin
         enSync1 <= opEnableReq;
         enSync2 <= enSync1;
         encSync1 <= encPulse;
         encSync2 <= encSync1;
         encPrev <= encSync2;
         posSync1 <= posPulse;
         posSync2 <= posSync1;
         posPrev <= posSync2;
      end
   end
   assign encEdge = encSync2 && !encPrev;
   assign posEdge = posSync2 && !posPrev;

   // bit n of the toggle counter is the train divided by 2^(n+1)
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         encDiv <= 6'h0;
         posDiv <= 6'h0;
      end else begin
         if (encEdge)
            encDiv <= encDiv + 6'h1;
         if (posEdge)
            posDiv <= posDiv + 6'h1;
      end
   end

   // brake sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         state <= ORBC_DISABLED;
      else
         state <= next_state;
   end

   always_comb begin
      next_state = state;
      unique case (state)
         ORBC_DISABLED:
            if (enSync2)
               next_state = ORBC_WAIT_ON;
         ORBC_WAIT_ON:
            if (!enSync2)
               next_state = ORBC_WAIT_ENGAGE;
            else if (msLeft == 16'h0)
               next_state = ORBC_WAIT_RUN;
         ORBC_WAIT_RUN:
            if (!enSync2)
               next_state = ORBC_WAIT_ENGAGE;
            else if (msLeft == 16'h0)
               next_state = ORBC_ENABLED;
         ORBC_ENABLED:
            if (!enSync2)
               next_state = ORBC_WAIT_ENGAGE;
         ORBC_WAIT_ENGAGE:
            if (motorStopped && msLeft == 16'h0)
               next_state = ORBC_WAIT_OFF;
         ORBC_WAIT_OFF:
            if (msLeft == 16'h0)
               next_state = ORBC_DISABLED;
      endcase
   end

   // millisecond down-counter, reloaded when a waiting step begins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         msLeft <= 16'h0;
         msTick <= 32'h0;
      end else if (next_state != state) begin
         msTick <= 32'h0;
         unique case (next_state)
            ORBC_WAIT_ON: msLeft <= delay[2];
            ORBC_WAIT_RUN: msLeft <= delay[3];
            ORBC_WAIT_ENGAGE: msLeft <= delay[0];
            ORBC_WAIT_OFF: msLeft <= delay[1];
            default: msLeft <= 16'h0;
         endcase
      end else if (state == ORBC_WAIT_ENGAGE && !motorStopped) begin
         // engage delay starts counting only once at standstill
         msTick <= 32'h0;
         msLeft <= delay[0];
      end else if (msLeft != 16'h0) begin
         if (msTick == 32'(MS_CYCLES - 1)) begin
            msTick <= 32'h0;
            msLeft <= msLeft - 16'h1;
         end else begin
            msTick <= msTick + 32'h1;
         end
      end
   end

   always_comb begin
      motorCurrentOn = state != ORBC_DISABLED;
      motionAllowed = state == ORBC_ENABLED;
      stopRequest = state == ORBC_WAIT_ENGAGE;
   end

   // release held from the release step until the engage step, so the
   // brake stays open while the motor is brought to a standstill;
   // an abort before release never opens it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         brakeReleased <= 1'b0;
      else if (next_state == ORBC_WAIT_RUN)
         brakeReleased <= 1'b1;
      else if (next_state == ORBC_WAIT_OFF || next_state == ORBC_DISABLED)
         brakeReleased <= 1'b0;
   end

   // brake pwm; period and on-time latch only at a period boundary
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwmCnt <= 32'h0;
         pwmPeriod <= 32'h1;
         pwmOn <= 32'h1;
      end else if (pwmCnt + 32'h1 >= pwmPeriod) begin
         pwmCnt <= 32'h0;
         pwmPeriod <= 32'(CLK_HZ) / {16'h0, pwmFreq};
         pwmOn <= 32'((64'(CLK_HZ) / {48'h0, pwmFreq}) * pwmDuty / 100);
      end else begin
         pwmCnt <= pwmCnt + 32'h1;
      end
   end
   assign pwmSig = pwmDuty == `ORBC_DUTY_MAX || pwmCnt < pwmOn;

   // slower outputs resample at a 500 Hz-class rate limit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         slowCnt <= 32'h0;
      end else if (slowTick) begin
         slowCnt <= 32'h0;
      end else begin
         slowCnt <= slowCnt + 32'h1;
      end
   end
   assign slowTick = slowCnt == 32'(CLK_HZ / (2 * `ORBC_SLOW_HZ) - 1);

   always_comb begin
      for (int i = 0; i < 5; i++) begin
         logic [7:0] src;
         logic ctl;
         src = route[i][15:8];
         ctl = ctrlWord[route[i][6:0] > 7'd31 ? 5'd0 : route[i][4:0]]
               ^ route[i][`ORBC_INV_BIT];
         if (src == 8'h00)
            routed[i] = 1'b1;
         else if (src == 8'h01)
            routed[i] = 1'b0;
         else if (src <= 8'h08)
            routed[i] = divSel(src, 8'h02, encSync2, encDiv);
         else if (src <= 8'h0f)
            routed[i] = divSel(src, 8'h09, posSync2, posDiv);
         else if (src == 8'h10)
            routed[i] = pwmSig;
         else if (src == 8'h11)
            routed[i] = !pwmSig;
         else
            routed[i] = 1'b0;
         routed[i] = routed[i] & ctl;
      end
   end

   // automatic brake carries the pwm; manual follows control bit 0
   assign brakeNorm = drvCfg[`ORBC_AUTO_BIT] ?
                      (brakeReleased && pwmSig) :
                      ctrlWord[`ORBC_BRAKE_BIT];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         outNow <= 5'h0;
      end else begin
         if (outCfg[`ORBC_ROUTE_EN_BIT]) begin
            // index 0 brake, 1..4 outputs; 3 and 4 are the slow ones
            outNow[2:0] <= routed[2:0];
            if (slowTick)
               outNow[4:3] <= routed[4:3];
         end else begin
            // normal path; config entries are not consulted while routing
            outNow[0] <= brakeNorm ^ outCfg[0];
            for (int i = 1; i < 5; i++)
               outNow[i] <= ctrlWord[`ORBC_OUT1_BIT + i - 1] ^ outCfg[i];
         end
      end
   end

   // open-drain brake pin: enable low pulls the brake line
   assign brakeOut = 1'b0;
   assign brakeOutOen = !outNow[0];
   assign digOut = outNow[4:1];

   motion_gate_a: assert property (
      @(posedge clk) disable iff (!resetn)
      motionAllowed |-> brakeReleased && motorCurrentOn)
      else $error("motion allowed with brake not released");
   brake_enabled_a: assert property (
      @(posedge clk) disable iff (!resetn)
      brakeReleased |->
      state inside {ORBC_WAIT_RUN, ORBC_ENABLED, ORBC_WAIT_ENGAGE})
      else $error("brake released outside enable");
   current_off_a: assert property (
      @(posedge clk) disable iff (!resetn)
      $fell(motorCurrentOn) |-> $past(state) == ORBC_WAIT_OFF)
      else $error("current off without engage wait");
   duty_full_a: assert property (
      @(posedge clk) disable iff (!resetn)
      drvCfg[`ORBC_AUTO_BIT] && !outCfg[`ORBC_ROUTE_EN_BIT] && !outCfg[0] &&
      brakeReleased && pwmDuty == `ORBC_DUTY_MAX |=> outNow[0])
      else $error("full duty brake not continuous");
   freq_range_a: assert property (
      @(posedge clk) disable iff (!resetn)
      pwmFreq <= `ORBC_FREQ_MAX && pwmFreq != 16'h0)
      else $error("pwm frequency out of range");
   const_high_a: assert property (
      @(posedge clk) disable iff (!resetn)
      outCfg[`ORBC_ROUTE_EN_BIT] && route[1] == 16'h0000 && ctrlWord[0]
      ##1 outCfg[`ORBC_ROUTE_EN_BIT] |-> digOut[0])
      else $error("constant high route not high");
   invert_ctl_a: assert property (
      @(posedge clk) disable iff (!resetn)
      outCfg[`ORBC_ROUTE_EN_BIT] && route[2] == 16'h0080 && ctrlWord[0]
      |=> !digOut[1])
      else $error("inverted control did not gate");
   manual_brake_a: assert property (
      @(posedge clk) disable iff (!resetn)
      !outCfg[`ORBC_ROUTE_EN_BIT] && !drvCfg[`ORBC_AUTO_BIT] && !outCfg[0]
      |=> outNow[0] == $past(ctrlWord[0]))
      else $error("manual brake not following bit 0");
endmodule
`default_nettype wire

// file: sim/orbc_brake_model.sv
// brake driver and pin model: open-drain brake pin with external pull-up
// assumes brakeOutOen low means the controller pulls the pin low
`timescale 1ns/1ps
`default_nettype none
module orbc_brake_model (
   input wire logic brakeOut,
   input wire logic brakeOutOen,
   output logic brakePin,
   output logic brakeReleased
);
   // undriven pin floats to the pull-up, never keeps the last level
   assign brakePin = brakeOutOen ? 1'b1 : brakeOut;
   // current through the coil only while the pin is pulled low
   assign brakeReleased = !brakePin;
endmodule
`default_nettype wire

// file: sim/tb.sv
// testbench: apb register tests, routing mux, dividers, brake sequencing
// assumes orbc_top with pready answering on its own; MS_CYCLES and CLK_HZ
// shortened so delays, the pwm period and the resample tick fit the run
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, err, encPulse = 0, posPulse = 0;
   logic opEnableReq = 0, motorStopped = 0, motorCurrentOn, motionAllowed;
   logic stopRequest, brakeOut, brakeOutOen, brakePin, brakeReleased, q0;
   logic [3:0] digOut;
   int n_errors = 0, compares = 0, rises = 0, wn, n0, c, j;
   always #5 clk = ~clk;
   always @(negedge clk) begin
      if (digOut[0] === 1'b1 && q0 === 1'b0) rises++;
      q0 = digOut[0];
   end
   orbc_top #(.MS_CYCLES(10), .CLK_HZ(100000)) i_dut (.clk(clk),
      .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .encPulse(encPulse), .posPulse(posPulse), .opEnableReq(opEnableReq),
      .motorStopped(motorStopped), .motorCurrentOn(motorCurrentOn),
      .motionAllowed(motionAllowed), .stopRequest(stopRequest),
      .brakeOut(brakeOut), .brakeOutOen(brakeOutOen), .digOut(digOut));
   orbc_brake_model i_brake (.brakeOut(brakeOut), .brakeOutOen(brakeOutOen),
      .brakePin(brakePin), .brakeReleased(brakeReleased));
   task automatic chk(input string nm, input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task conclude;
      $display("mismatches %0d comparisons %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         n_errors++;
         conclude();
      end
   endtask
   task automatic wr(input logic [11:0] a, input [31:0] d);
      apb(1'b1, a, d);
      repeat (4) @(posedge clk);
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input [31:0] e);
      apb(1'b0, a, 0);
      chk(nm, rd, e);
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return brakeReleased;
         1: return motionAllowed;
         2: return motorCurrentOn;
         default: return stopRequest;
      endcase
   endfunction
   task automatic waitv(input int s, input logic v);
      wn = 0;
      do begin
         @(posedge clk);
         wn++;
      end while (sig(s) !== v && wn < 2000);
      if (wn >= 2000) begin
         n_errors++;
         conclude();
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      for (c = 0; c < 5; c++) rdc("route", 12'(4 * c), 32'h100);
      rdc("freq", 12'h030, 32'h7d0);
      rdc("duty", 12'h034, 32'h64);
      rdc("unmapped", 12'h03c, 0);
      chk("slverr", err, 1);
      // out-of-range settings must leave the old value
      wr(12'h030, 0);
      wr(12'h030, 32'h7d1);
      rdc("freqRef", 12'h030, 32'h7d0);
      wr(12'h034, 0);
      wr(12'h034, 32'h65);
      rdc("dutyRef", 12'h034, 32'h64);
      wr(12'h034, 32'h32);
      rdc("dutyOk", 12'h034, 32'h32);
      wr(12'h034, 32'h64);
      wr(12'h014, 32'h90000);
      chk("normOut1", digOut[0], 1);
      chk("normOut4", digOut[3], 1);
      wr(12'h018, 32'h2);
      chk("normPol", digOut[0], 0);
      wr(12'h018, 32'h102);
      wr(12'h004, 32'h5);
      wr(12'h014, 32'h20);
      chk("routeHigh", digOut[0], 1);
      wr(12'h014, 0);
      chk("routeGate", digOut[0], 0);
      wr(12'h004, 32'h85);
      chk("routeInv", digOut[0], 1);
      wr(12'h004, 32'h185);
      chk("routeLow", digOut[0], 0);
      wr(12'h008, 32'h80);
      chk("out2", digOut[1], 1);
      wr(12'h014, 32'h20);
      for (c = 2; c < 16; c++) begin
         wr(12'h004, {16'h0, 8'(c), 8'h05});
         repeat (8) @(posedge clk);
         n0 = rises;
         for (j = 0; j < 64; j++) begin
            @(posedge clk);
            encPulse <= (c < 9);
            posPulse <= (c >= 9);
            repeat (3) @(posedge clk);
            encPulse <= 1'b0;
            posPulse <= 1'b0;
            repeat (3) @(posedge clk);
         end
         repeat (8) @(posedge clk);
         chk("divRises", rises - n0, 64 >> ((c - 2) % 7));
      end
      // manual brake follows control bit 0 only while automatic is off
      wr(12'h018, 0);
      wr(12'h01c, 0);
      wr(12'h014, 32'h1);
      chk("manRel", brakeReleased, 1);
      wr(12'h014, 0);
      chk("manEng", brakeReleased, 0);
      wr(12'h01c, 32'h4);
      wr(12'h014, 32'h1);
      chk("autoHold", brakeReleased, 0);
      wr(12'h020, 32'h1);
      wr(12'h024, 32'h2);
      wr(12'h028, 32'h3);
      wr(12'h02c, 32'h2);
      @(posedge clk);
      opEnableReq <= 1'b1;
      waitv(2, 1'b1);
      chk("curOnT", wn <= 5, 1);
      waitv(0, 1'b1);
      chk("relT", wn >= 28 && wn <= 33, 1);
      chk("noMotion", motionAllowed, 0);
      waitv(1, 1'b1);
      chk("motionT", wn >= 18 && wn <= 23, 1);
      n0 = 0;
      repeat (200) begin
         @(posedge clk);
         if (brakeReleased !== 1'b1) n0++;
      end
      chk("duty100", n0, 0);
      // half duty at a 50-cycle period: any 100 cycles hold 50 released
      wr(12'h034, 32'h32);
      repeat (60) @(posedge clk);
      n0 = 0;
      repeat (100) begin
         @(posedge clk);
         if (brakeReleased === 1'b1) n0++;
      end
      chk("duty50", n0, 50);
      wr(12'h034, 32'h64);
      wr(12'h018, 32'h100);
      wr(12'h004, 0);
      chk("routeConst", digOut[0], 1);
      wr(12'h00c, 0);
      repeat (100) @(posedge clk);
      chk("out3Slow", digOut[2], 1);
      chk("out2Off", digOut[1], 0);
      wr(12'h004, 32'h1000);
      chk("pwmRoute", digOut[0], 1);
      wr(12'h004, 32'h1100);
      chk("pwmInv", digOut[0], 0);
      wr(12'h018, 0);
      opEnableReq <= 1'b0;
      waitv(3, 1'b1);
      repeat (20) @(posedge clk);
      chk("holdMoving", brakeReleased, 1);
      motorStopped <= 1'b1;
      waitv(0, 1'b0);
      chk("engT", wn >= 8 && wn <= 14, 1);
      chk("curStill", motorCurrentOn, 1);
      waitv(2, 1'b0);
      chk("offT", wn >= 18 && wn <= 23, 1);
      conclude();
   end
endmodule
`default_nettype wire
